// >>> shared/ams_pkg.sv
// Constants, types and timing figures of the analog measurement supervisor.
// Assumes magnitudes and angles arrive from measurement logic on the same clock.

package ams_pkg;

  // ****************************************************************
  // Data formats
  // ****************************************************************
  // Voltage LSB is 1 V primary, current LSB is 0.1 A primary.
  // Angle is voltage-to-current shift in tenths of a degree, 0 to 3599.
  localparam int AMS_MAG_W = 16;
  localparam int AMS_NUM_PH = 3;
  localparam int AMS_PROD_W = 19;
  localparam logic [AMS_PROD_W-1:0] AMS_SEQ_DIV = 19'h0_0005;
  localparam logic [AMS_MAG_W-1:0] AMS_I_THR = 16'h0032;
  localparam logic [AMS_MAG_W-1:0] AMS_V_THR = 16'h0064;
  localparam logic [AMS_MAG_W-1:0] AMS_OUT_LO = 16'h0c80;
  localparam logic [AMS_MAG_W-1:0] AMS_OUT_HI = 16'h00c8;
  localparam logic [AMS_MAG_W-1:0] AMS_INC_LO = 16'h0578;
  localparam logic [AMS_MAG_W-1:0] AMS_INC_HI = 16'h07d0;

  // ****************************************************************
  // Persistence timing
  // ****************************************************************
  localparam longint AMS_CLK_HZ = 100000000;
  localparam longint AMS_PERSIST_S = 10;
  localparam int unsigned AMS_PERSIST_CYC = int'(AMS_PERSIST_S * AMS_CLK_HZ);
  localparam int AMS_CNT_W = 30;

  // ****************************************************************
  // Persistence state machine
  // ****************************************************************
  typedef enum logic [2:0] {
    AMS_ST_IDLE = 3'b001,
    AMS_ST_TIMING = 3'b010,
    AMS_ST_FAIL = 3'b100
  } ams_state_t;

  typedef logic [AMS_NUM_PH-1:0][AMS_MAG_W-1:0] ams_phase_vec_t;

endpackage : ams_pkg

// >>> shared/ams_phase_if.sv
// Interface carrying per-phase measurements to the concordance check.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
`default_nettype none

interface ams_phase_if;
  import ams_pkg::*;
  ams_phase_vec_t i_mag;
  ams_phase_vec_t v_mag;
  ams_phase_vec_t ang;
  logic fault;
  logic [AMS_NUM_PH-1:0] qual;

  modport src (output i_mag, output v_mag, output ang, input fault, input qual);
  modport chk (input i_mag, input v_mag, input ang, output fault, output qual);
endinterface : ams_phase_if

`default_nettype wire

// >>> verilog/ams_concord.sv
// Voltage-to-current phase concordance check, purely combinational.
// Assumes magnitudes and angles are stable on the clock of the instantiating module.
`timescale 1ns/1ps
`default_nettype none

module ams_concord
  import ams_pkg::*;
(
  ams_phase_if.chk ph // Per-phase data in, concordance fault out.
);

  logic [AMS_NUM_PH-1:0] q_ph;
  logic [AMS_NUM_PH-1:0] out_ph;
  logic [AMS_NUM_PH-1:0] inc_ph;

  // ****************************************************************
  // Per-phase classification
  // ****************************************************************
  for (genvar g = 0; g < AMS_NUM_PH; g++) begin : g_ph
    assign q_ph[g] = (ph.i_mag[g] > AMS_I_THR) && (ph.v_mag[g] > AMS_V_THR);
    // The outgoing window wraps through zero degrees.
    assign out_ph[g] = q_ph[g] && ((ph.ang[g] >= AMS_OUT_LO) || (ph.ang[g] <= AMS_OUT_HI));
    assign inc_ph[g] = q_ph[g] && (ph.ang[g] >= AMS_INC_LO) && (ph.ang[g] <= AMS_INC_HI);
  end

  // ****************************************************************
  // Fault decision
  // ****************************************************************
  // An all-zero qualifier vector leaves every term below false.
  assign ph.fault = (|(q_ph & ~out_ph & ~inc_ph)) || ((|out_ph) && (|inc_ph));
  assign ph.qual = q_ph;

endmodule : ams_concord

`default_nettype wire

// >>> verilog/ams_supervisor.sv
// Analog measurement supervisor: three sub-unit checks and a persistence timer.
// Assumes all measurement inputs come from logic on i_sys_clk, refreshed each cycle.
`timescale 1ns/1ps
`default_nettype none

module ams_supervisor
  import ams_pkg::*;
#(
  parameter int unsigned P_PERSIST_CYC = AMS_PERSIST_CYC // Persistence length in cycles.
) (
  input wire logic i_sys_clk, // System clock, 100 MHz.
  input wire logic i_rstn, // Asynchronous reset, active low.
  input wire logic [AMS_MAG_W-1:0] i_v1_mag, // Positive sequence voltage magnitude.
  input wire logic [AMS_MAG_W-1:0] i_v2_mag, // Negative sequence voltage magnitude.
  input wire ams_phase_vec_t i_ph_i_mag, // Per-phase current magnitude.
  input wire ams_phase_vec_t i_ph_v_mag, // Per-phase voltage magnitude.
  input wire ams_phase_vec_t i_ph_ang, // Per-phase voltage-to-current angle.
  input wire logic i_inval_enable, // Setting: failure invalidates analog signals.
  output logic o_seq_fault, // Sequence sub-unit flag, registered.
  output logic o_cur_fault, // Current sub-unit flag, registered.
  output logic o_conc_fault, // Concordance sub-unit flag, registered.
  output logic [AMS_NUM_PH-1:0] o_ph_qual, // Phases above both thresholds, registered.
  output logic o_timing, // Persistence timer running.
  output logic o_measurement_chain_failure, // Measurement failure, registered.
  output logic o_analog_invalid // Invalidity bit for every analog signal.
);

  ams_phase_if ph ();

  logic seq_fault_d;
  logic cur_fault_d;
  logic seq_fault_q;
  logic cur_fault_q;
  logic conc_fault_q;
  logic [AMS_NUM_PH-1:0] qual_q;
  logic any_fault;
  logic [AMS_NUM_PH-1:0] cur_ph;
  logic [AMS_PROD_W-1:0] v2_scaled;
  logic [AMS_PROD_W-1:0] v1_wide;
  ams_state_t state_q;
  ams_state_t state_d;
  logic [AMS_CNT_W-1:0] cnt_q;
  logic cnt_done;
  logic fail_q;
  logic inval_q;
  logic conc_fault_d;
  logic [AMS_NUM_PH-1:0] qual_d;
  logic [AMS_CNT_W-1:0] cnt_d;
  logic fail_d;
  logic inval_d;

  localparam logic [AMS_CNT_W-1:0] CNT_LAST = AMS_CNT_W'(P_PERSIST_CYC - 1);

  // ****************************************************************
  // Voltage sequence check
  // ****************************************************************
  // Scaling V2 by five avoids a divider; the product cannot overflow.
  assign v2_scaled = AMS_PROD_W'(i_v2_mag) * AMS_SEQ_DIV;
  assign v1_wide = AMS_PROD_W'(i_v1_mag);
  assign seq_fault_d = (v2_scaled >= v1_wide);

  // ****************************************************************
  // Current without voltage check
  // ****************************************************************
  for (genvar g = 0; g < AMS_NUM_PH; g++) begin : g_cur
    assign cur_ph[g] = (i_ph_i_mag[g] > AMS_I_THR) && (i_ph_v_mag[g] < AMS_V_THR);
  end
  assign cur_fault_d = |cur_ph;

  // ****************************************************************
  // Phase concordance check
  // ****************************************************************
  assign ph.i_mag = i_ph_i_mag;
  assign ph.v_mag = i_ph_v_mag;
  assign ph.ang = i_ph_ang;

  ams_concord u_concord (
    .ph(ph.chk)
  );

  // ****************************************************************
  // Concordance next values
  // ****************************************************************
  assign conc_fault_d = ph.fault;
  assign qual_d = ph.qual;

  // ****************************************************************
  // Sub-unit flag registers
  // ****************************************************************
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      seq_fault_q <= 1'b0;
    end else begin
      seq_fault_q <= seq_fault_d;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cur_fault_q <= 1'b0;
    end else begin
      cur_fault_q <= cur_fault_d;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      conc_fault_q <= 1'b0;
    end else begin
      conc_fault_q <= conc_fault_d;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      qual_q <= '0;
    end else begin
      qual_q <= qual_d;
    end
  end

  // ****************************************************************
  // Combined fault flag
  // ****************************************************************
  assign any_fault = seq_fault_q | cur_fault_q | conc_fault_q;

  // ****************************************************************
  // Persistence state machine
  // ****************************************************************
  assign cnt_done = (cnt_q == CNT_LAST);

  always_comb begin
    state_d = state_q;
    case (state_q)
      AMS_ST_IDLE: begin
        if (any_fault) begin
          state_d = AMS_ST_TIMING;
        end
      end
      AMS_ST_TIMING: begin
        if (!any_fault) begin
          state_d = AMS_ST_IDLE;
        end else if (cnt_done) begin
          state_d = AMS_ST_FAIL;
        end
      end
      AMS_ST_FAIL: begin
        if (!any_fault) begin
          state_d = AMS_ST_IDLE;
        end
      end
      default: begin
        state_d = AMS_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_q <= AMS_ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ****************************************************************
  // Persistence counter
  // ****************************************************************
  // The count only advances while the combined flag stays high.
  always_comb begin
    cnt_d = cnt_q;
    if (state_q != AMS_ST_TIMING || !any_fault) begin
      cnt_d = '0;
    end else if (!cnt_done) begin
      cnt_d = cnt_q + AMS_CNT_W'(1);
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // ****************************************************************
  // Failure output
  // ****************************************************************
  // Only the invalidity output reacts to the failure; blocking is left to user logic.
  assign fail_d = (state_d == AMS_ST_FAIL);

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      fail_q <= 1'b0;
    end else begin
      fail_q <= fail_d;
    end
  end

  // ****************************************************************
  // Invalidity output
  // ****************************************************************
  assign inval_d = fail_d && i_inval_enable;

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      inval_q <= 1'b0;
    end else begin
      inval_q <= inval_d;
    end
  end

  // ****************************************************************
  // Port outputs
  // ****************************************************************
  assign o_seq_fault = seq_fault_q;
  assign o_cur_fault = cur_fault_q;
  assign o_conc_fault = conc_fault_q;
  assign o_ph_qual = qual_q;
  assign o_timing = (state_q == AMS_ST_TIMING);
  assign o_measurement_chain_failure = fail_q;
  assign o_analog_invalid = inval_q;

endmodule : ams_supervisor

`default_nettype wire

// >>> verif/ams_supervisor_monitor.sv
// Concurrent checks on the ports of the measurement supervisor.
// Assumes one clock domain and the reset that the top module receives.
`timescale 1ns/1ps
`default_nettype none
module ams_supervisor_monitor
  import ams_pkg::*;
#(
  parameter int unsigned P_PERSIST_CYC = AMS_PERSIST_CYC // Persistence length in cycles.
) (
  input wire logic i_sys_clk, // Clock.
  input wire logic i_rstn, // Reset, active low.
  input wire logic [AMS_MAG_W-1:0] i_v1_mag, // Positive sequence voltage.
  input wire logic [AMS_MAG_W-1:0] i_v2_mag, // Negative sequence voltage.
  input wire ams_phase_vec_t i_ph_i_mag, // Phase currents.
  input wire ams_phase_vec_t i_ph_v_mag, // Phase voltages.
  input wire ams_phase_vec_t i_ph_ang, // Phase angles.
  input wire logic i_inval_enable, // Invalidity setting.
  input wire logic o_seq_fault, // Sequence flag.
  input wire logic o_cur_fault, // Current flag.
  input wire logic o_conc_fault, // Concordance flag.
  input wire logic [AMS_NUM_PH-1:0] o_ph_qual, // Qualifying phases.
  input wire logic o_timing, // Timer running.
  input wire logic o_measurement_chain_failure, // Failure output.
  input wire logic o_analog_invalid // Invalidity output.
);
  // ****
  // Reference flags and run counter
  // ****
  logic [AMS_NUM_PH-1:0] qual_w, cur_w, out_w, in_w;
  logic conc_w, any_fault;
  logic [AMS_CNT_W-1:0] cnt_q;
  always_comb begin
    for (int p = 0; p < AMS_NUM_PH; p++) begin
      qual_w[p] = i_ph_i_mag[p] > AMS_I_THR && i_ph_v_mag[p] > AMS_V_THR;
      cur_w[p] = i_ph_i_mag[p] > AMS_I_THR && i_ph_v_mag[p] < AMS_V_THR;
      out_w[p] = i_ph_ang[p] >= AMS_OUT_LO || i_ph_ang[p] <= AMS_OUT_HI;
      in_w[p] = i_ph_ang[p] >= AMS_INC_LO && i_ph_ang[p] <= AMS_INC_HI;
    end
  end
  assign conc_w = |(qual_w & ~out_w & ~in_w) || (|(qual_w & out_w) && |(qual_w & in_w));
  assign any_fault = o_seq_fault | o_cur_fault | o_conc_fault;
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) cnt_q <= '0;
    else cnt_q <= any_fault ? cnt_q + 1'b1 : '0;
  end
  // ****
  // Assertions
  // ****
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  sequence s_full;
    any_fault && cnt_q == P_PERSIST_CYC;
  endsequence
  a_seq_ratio: assert property ($past(i_rstn) |->
    o_seq_fault == ($past(i_v2_mag) * 5 >= $past(i_v1_mag))) else $error("sequence flag wrong");
  a_cur_flag: assert property ($past(i_rstn) |-> o_cur_fault == $past(|cur_w))
    else $error("current flag wrong");
  a_qual_mask: assert property ($past(i_rstn) |-> o_ph_qual == $past(qual_w))
    else $error("qualify mask wrong");
  a_conc_flag: assert property ($past(i_rstn) |-> o_conc_fault == $past(conc_w))
    else $error("concordance flag wrong");
  a_fail_early: assert property (o_measurement_chain_failure |-> cnt_q > P_PERSIST_CYC)
    else $error("failure too early");
  a_fail_late: assert property (s_full |=> o_measurement_chain_failure)
    else $error("failure too late");
  a_timer_run: assert property (any_fault |=> o_timing || o_measurement_chain_failure)
    else $error("timer not running");
  a_fail_drop: assert property (!any_fault |=> !o_measurement_chain_failure && !o_timing)
    else $error("failure not cleared");
  a_invalid_gate: assert property ($past(i_rstn) |->
    o_analog_invalid == (o_measurement_chain_failure && $past(i_inval_enable)))
    else $error("invalidity wrong");
endmodule : ams_supervisor_monitor
bind ams_supervisor ams_supervisor_monitor #(.P_PERSIST_CYC(P_PERSIST_CYC)) u_mon (
  .i_sys_clk(i_sys_clk),
  .i_rstn(i_rstn),
  .i_v1_mag(i_v1_mag),
  .i_v2_mag(i_v2_mag),
  .i_ph_i_mag(i_ph_i_mag),
  .i_ph_v_mag(i_ph_v_mag),
  .i_ph_ang(i_ph_ang),
  .i_inval_enable(i_inval_enable),
  .o_seq_fault(o_seq_fault),
  .o_cur_fault(o_cur_fault),
  .o_conc_fault(o_conc_fault),
  .o_ph_qual(o_ph_qual),
  .o_timing(o_timing),
  .o_measurement_chain_failure(o_measurement_chain_failure),
  .o_analog_invalid(o_analog_invalid)
);
`default_nettype wire

// >>> verif/ams_front_model.sv
// Measurement front end model: one of eight fixed measurement sets.
// Assumes the selector changes just after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module ams_front_model
  import ams_pkg::*;
(
  input wire logic [2:0] i_sel, // Measurement set to present.
  output logic [AMS_MAG_W-1:0] o_v1, // Positive sequence voltage.
  output logic [AMS_MAG_W-1:0] o_v2, // Negative sequence voltage.
  output var ams_phase_vec_t o_ph_i, // Phase currents.
  output var ams_phase_vec_t o_ph_v, // Phase voltages.
  output var ams_phase_vec_t o_ph_a // Phase angles.
);
  // Default set is a loaded outgoing line with every value on or one step from a limit, except the zero-degree angle of phase 0.
  always_comb begin
    o_v1 = 16'h03e8;
    o_v2 = 16'h00c7;
    o_ph_i = {3{16'h0033}};
    o_ph_v = {3{16'h0065}};
    o_ph_a = {16'h0c80, 16'h00c8, 16'h0000};
    case (i_sel)
      3'h0: o_ph_i = {3{16'h0032}};
      3'h1: o_v2 = 16'h00c8;
      3'h2: o_ph_v[0] = 16'h0063;
      3'h4: o_ph_a = {16'h0578, 16'h07d0, 16'h0708};
      3'h5: o_ph_a[1] = 16'h0708;
      3'h6: o_ph_a[0] = 16'h00c9;
      3'h7: o_ph_v = {3{16'h0064}};
      default: o_v2 = 16'h00c7;
    endcase
  end
endmodule : ams_front_model
`default_nettype wire

// >>> verif/analog_measurement_supervision_bench.sv
// Self-checking bench for the measurement supervisor.
// Assumes a short persistence count so that failures appear quickly.
`timescale 1ns/1ps
`default_nettype none
module analog_measurement_supervision_bench;
  import ams_pkg::*;
  localparam int unsigned P = 20;
  localparam logic [5:0] EXP [8] = '{6'h00, 6'h27, 6'h16, 6'h07, 6'h07, 6'h0f, 6'h0f, 6'h00};
  logic i_sys_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic i_inval_enable = 1'b0;
  logic [2:0] sel = 3'h0;
  logic [AMS_MAG_W-1:0] v1, v2;
  ams_phase_vec_t ph_i, ph_v, ph_a;
  logic sf, cf, kf, tm, fl, iv;
  logic [AMS_NUM_PH-1:0] q;
  int fail_count = 0;
  int comparisons = 0;
  always #5 i_sys_clk = ~i_sys_clk;
  ams_front_model u_ams_front_model (.i_sel(sel), .o_v1(v1), .o_v2(v2), .o_ph_i(ph_i),
    .o_ph_v(ph_v), .o_ph_a(ph_a));
  ams_supervisor #(.P_PERSIST_CYC(P)) u_ams_supervisor (.i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn), .i_v1_mag(v1), .i_v2_mag(v2), .i_ph_i_mag(ph_i), .i_ph_v_mag(ph_v),
    .i_ph_ang(ph_a), .i_inval_enable(i_inval_enable), .o_seq_fault(sf), .o_cur_fault(cf),
    .o_conc_fault(kf), .o_ph_qual(q), .o_timing(tm), .o_measurement_chain_failure(fl),
    .o_analog_invalid(iv));
  task summarize;
    if (fail_count == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize
  task check(input string n, input logic [15:0] s, input logic [15:0] e);
    comparisons++;
    if (s !== e) begin
      $display("mismatch %s expected %h seen %h", n, e, s);
      fail_count++;
    end
  endtask : check
  task tick(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask : tick
  task t_cases;
    for (int c = 0; c < 8; c++) begin
      sel = c[2:0];
      tick(2);
      check("flags", {10'h000, sf, cf, kf, q}, {10'h000, EXP[c]});
    end
  endtask : t_cases
  task t_persist(input logic en);
    int n;
    n = 0;
    sel = 3'h1;
    i_inval_enable = en;
    while (fl !== 1'b1) begin
      tick(1);
      n++;
      if (n > 40) begin
        fail_count++;
        summarize();
      end
    end
    check("latency", n[15:0], P + 2);
    check("invalid", iv, en);
    i_inval_enable = ~en;
    tick(1);
    check("invalid", iv, !en);
    sel = 3'h0;
    tick(2);
    check("cleared", {fl, iv, tm}, 3'b000);
  endtask : t_persist
  task t_restart;
    sel = 3'h5;
    tick(P);
    check("timing", tm, 1'b1);
    sel = 3'h0;
    tick(1);
    sel = 3'h2;
    tick(P);
    check("restart", fl, 1'b0);
    tick(3);
    check("failed", fl, 1'b1);
    sel = 3'h0;
    tick(3);
  endtask : t_restart
  initial begin
    repeat (8) @(posedge i_sys_clk);
    #1;
    i_rstn = 1'b1;
    check("reset", {sf, cf, kf, q, tm, fl, iv}, 9'h000);
    t_cases();
    t_persist(1'b1);
    t_persist(1'b0);
    t_restart();
    summarize();
  end
endmodule : analog_measurement_supervision_bench
`default_nettype wire
